// ==== logic/tmr_pkg.sv ====
package tmr_pkg;

  localparam int unsigned NCH = 5;
  localparam int unsigned NSRC = 15;
  localparam int unsigned NDMA = 4;
  localparam int unsigned CW = 16;

  // per-channel register block: channel n at CH_BASE + n*CH_STRIDE
  localparam logic [11:0] CH_BASE = 12'h000;
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [4:0] OFS_COUNT = 5'h00;
  localparam logic [4:0] OFS_GRA = 5'h04;
  localparam logic [4:0] OFS_GRB = 5'h08;
  localparam logic [4:0] OFS_BUFA = 5'h0C;
  localparam logic [4:0] OFS_CTRL = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam logic [4:0] OFS_IEN = 5'h18;
  // global registers
  localparam logic [11:0] ADDR_SYNC = 12'h100;
  localparam logic [11:0] ADDR_DMAEN = 12'h104;
  localparam logic [11:0] ADDR_PRIO_FIRST = 12'h108;
  localparam logic [11:0] ADDR_PRIO_SECOND = 12'h10C;
  localparam logic [11:0] ADDR_COMBO = 12'h110;
  localparam logic [11:0] ADDR_PEND = 12'h114;

  // ctrl fields
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_CLR_A = 1;
  localparam int unsigned CTRL_CLR_B = 2;
  localparam int unsigned CTRL_CAP_A = 3;
  localparam int unsigned CTRL_CAP_B = 4;
  localparam int unsigned CTRL_BUF_A = 5;
  localparam int unsigned CTRL_DOWN = 6;
  localparam int unsigned CTRL_W = 7;
  // status flag positions
  localparam int unsigned ST_A = 0;
  localparam int unsigned ST_B = 1;
  localparam int unsigned ST_WRAP = 2;

  localparam logic [CW-1:0] COUNT_RST = 16'h0000;
  localparam logic [CW-1:0] GR_RST = 16'hFFFF;
  localparam logic [CW-1:0] ALL_ONES = 16'hFFFF;

  typedef enum logic [2:0]
  {
    BUS_IDLE = 3'b001,
    BUS_SETUP = 3'b010,
    BUS_ACCESS = 3'b100
  } bus_state_t;

  typedef struct packed
  {
    logic [CW-1:0] count;
    logic [CW-1:0] gra;
    logic [CW-1:0] grb;
    logic [CW-1:0] bufa;
    logic [CTRL_W-1:0] ctrl;
    logic [2:0] stat;
    logic [2:0] ien;
    logic [2:0] armed;
  } chan_t;

  typedef struct packed
  {
    logic [NCH-1:0] incr;
    logic [NCH-1:0] cap_a;
    logic [NCH-1:0] cap_b;
  } evt_t;

endpackage

// ==== logic/grant_pick.sv ====
// fixed-priority pick among the pending sources, index 0 highest
module grant_pick
  import tmr_pkg::*;
#(
  parameter int unsigned N = NSRC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] req,
  output logic [N-1:0] grant_q
);

  initial
  begin
    if (N < 1)
    begin
      $error("grant_pick needs at least one source");
    end
  end

  logic [N-1:0] grant_d;

  always_comb
  begin
    grant_d = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        grant_d = '0;
        grant_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      grant_q <= '0;
    end
    else
    begin
      grant_q <= grant_d;
    end
  end

endmodule // grant_pick

// ==== logic/timer_irq_unit.sv ====
// Behaviour
// - flag clears only by a read seeing 1 followed by a write of 0.
// - five channels, three sources each: match A, match B, wrap; fifteen lines.
// - request line high only while flag and its enable are both 1.
// - channels 0-3 match A may go to dma; then no cpu request; ch4 never.
// - reset priority ch0 A,B,wrap down to ch4 wrap; prio_reg_first reorders channels, prio_reg_second is unused.
// - counter clear in the write-commit state wins; cpu write dropped.
// - word write to counter wins over a same-state increment.
// - byte write wins over increment; other byte keeps its old value.
// - general register write suppresses a compare match in that state.
// - write to counter beats wrap step, but wrap flag still sets.
// - capture during register read returns the pre-capture value.
// - capture-clear with increment clears, drops step, captures pre-clear count.
// - capture during general register write wins; write dropped.
// - buffered capture during buffer write wins; write dropped.
// - compare clear happens on the step leaving the match; period is value plus one.
// - byte write to a synchronised counter loads the full value into the group.
// - wrap flag sets on ffff to 0000 up, or 0000 to ffff down.
module timer_irq_unit
  import tmr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input evt_t evt,
  output logic [NSRC-1:0] irq_lines,
  output logic [NSRC-1:0] irq_grant,
  output logic [NDMA-1:0] dma_ctrl_req
);

  typedef struct packed
  {
    chan_t [NCH-1:0] ch;
    logic [NCH-1:0] sync;
    logic [NDMA-1:0] dma_en;
    logic [15:0] prio_reg_first;
    logic [15:0] prio_reg_second;
    logic [NCH-1:0] prio_map;
    logic combo_mode_hi;
    logic combo_mode_lo;
    logic [31:0] rdata;
    logic [NDMA-1:0] dma;
  } state_t;

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // bus decode: the access phase is the commit state of a cycle

  logic acc;
  logic [4:0] ofs;
  logic [2:0] chn;
  logic in_ch;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] ordered;
  logic [NSRC-1:0] grant_ord;

  assign acc = psel && penable;
  assign ofs = paddr[4:0];
  assign chn = paddr[7:5];
  assign in_ch = (paddr[11:8] == CH_BASE[11:8]) && (paddr[7:5] < 3'(NCH));
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = s_q.rdata;

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        pend[c*3+k] = s_q.ch[c].stat[k] && s_q.ch[c].ien[k];
        if (k == ST_A && c < NDMA && s_q.dma_en[c])
        begin
          pend[c*3+k] = 1'b0;
        end
      end
    end
  end

  assign irq_lines = pend;
  assign dma_ctrl_req = s_q.dma;

  // channel order for arbitration: channels with a prio bit set go first
  always_comb
  begin
    int pos;
    pos = 0;
    ordered = '0;
    for (int pass = 1; pass >= 0; pass--)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (s_q.prio_reg_first[c] == pass[0])
        begin
          ordered[pos*3 +: 3] = pend[c*3 +: 3];
          pos = pos + 1;
        end
      end
    end
  end

  grant_pick #(.N(NSRC)) u_pick
  (
    .pclk(pclk),
    .presetn(presetn),
    .req(ordered),
    .grant_q(grant_ord)
  );

  // map the winning slot back to its own source line
  always_comb
  begin
    int pos;
    pos = 0;
    irq_grant = '0;
    for (int pass = 1; pass >= 0; pass--)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        // order as it stood when the registered pick was made
        if (s_q.prio_map[c] == pass[0])
        begin
          irq_grant[c*3 +: 3] = grant_ord[pos*3 +: 3] & pend[c*3 +: 3];
          pos = pos + 1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counting, capture and contention

  always_comb
  begin
    logic wr;
    logic rd;
    logic hit;
    logic [CW-1:0] cnt;
    logic [CW-1:0] nxt;
    logic [CW-1:0] wval;
    logic match_a;
    logic match_b;
    logic clr;
    logic wrap;
    logic byte_wr;
    logic sync_wr;
    logic [CW-1:0] sync_val;
    wr = 1'b0;
    rd = 1'b0;
    hit = 1'b0;
    cnt = '0;
    nxt = '0;
    wval = '0;
    match_a = 1'b0;
    match_b = 1'b0;
    clr = 1'b0;
    wrap = 1'b0;
    byte_wr = 1'b0;
    sync_wr = 1'b0;
    sync_val = '0;
    s_d = s_q;
    s_d.dma = '0;
    s_d.prio_map = s_q.prio_reg_first[NCH-1:0];

    // a synchronised counter written this cycle feeds its whole value to the group
    for (int c = 0; c < NCH; c++)
    begin
      if (acc && pwrite && in_ch && chn == 3'(c) && ofs == OFS_COUNT && s_q.sync[c])
      begin
        sync_wr = 1'b1;
        sync_val = s_q.ch[c].count;
        if (pstrb[0])
        begin
          sync_val[7:0] = pwdata[7:0];
        end
        if (pstrb[1])
        begin
          sync_val[15:8] = pwdata[15:8];
        end
      end
    end

    for (int c = 0; c < NCH; c++)
    begin
      hit = acc && in_ch && chn == 3'(c);
      wr = hit && pwrite;
      rd = hit && !pwrite;
      cnt = s_q.ch[c].count;
      wval = cnt;
      if (pstrb[0])
      begin
        wval[7:0] = pwdata[7:0];
      end
      if (pstrb[1])
      begin
        wval[15:8] = pwdata[15:8];
      end
      byte_wr = pstrb[1:0] != 2'b11;
      nxt = s_q.ch[c].ctrl[CTRL_DOWN] ? cnt - 16'h0001 : cnt + 16'h0001;
      // match is taken on the step that leaves the matching count
      match_a = evt.incr[c] && !s_q.ch[c].ctrl[CTRL_CAP_A] && cnt == s_q.ch[c].gra;
      match_b = evt.incr[c] && !s_q.ch[c].ctrl[CTRL_CAP_B] && cnt == s_q.ch[c].grb;
      if (wr && ofs == OFS_GRA)
      begin
        match_a = 1'b0;
      end
      if (wr && ofs == OFS_GRB)
      begin
        match_b = 1'b0;
      end
      wrap = evt.incr[c] && s_q.ch[c].ctrl[CTRL_RUN] &&
        (s_q.ch[c].ctrl[CTRL_DOWN] ? cnt == COUNT_RST : cnt == ALL_ONES);
      clr = (s_q.ch[c].ctrl[CTRL_CLR_A] &&
             (match_a || (evt.cap_a[c] && s_q.ch[c].ctrl[CTRL_CAP_A]))) ||
            (s_q.ch[c].ctrl[CTRL_CLR_B] &&
             (match_b || (evt.cap_b[c] && s_q.ch[c].ctrl[CTRL_CAP_B])));

      // counter: clear beats write beats increment
      if (clr)
      begin
        s_d.ch[c].count = COUNT_RST;
      end
      else if (wr && ofs == OFS_COUNT)
      begin
        s_d.ch[c].count = byte_wr ? wval : pwdata[CW-1:0];
      end
      else if (sync_wr && s_q.sync[c])
      begin
        s_d.ch[c].count = sync_val;
      end
      else if (psel && !penable && pwrite && in_ch && chn == 3'(c) &&
               ofs == OFS_COUNT && byte_wr)
      begin
        // a step in the setup state of a byte write is lost too
        s_d.ch[c].count = cnt;
      end
      else if (evt.incr[c] && s_q.ch[c].ctrl[CTRL_RUN])
      begin
        s_d.ch[c].count = nxt;
      end

      // general registers: capture beats cpu write
      if (evt.cap_a[c] && s_q.ch[c].ctrl[CTRL_CAP_A])
      begin
        s_d.ch[c].gra = cnt;
        if (s_q.ch[c].ctrl[CTRL_BUF_A])
        begin
          s_d.ch[c].bufa = s_q.ch[c].gra;
        end
        else if (wr && ofs == OFS_BUFA)
        begin
          s_d.ch[c].bufa = pwdata[CW-1:0];
        end
      end
      else
      begin
        if (wr && ofs == OFS_GRA)
        begin
          s_d.ch[c].gra = pwdata[CW-1:0];
        end
        else if (match_a && s_q.ch[c].ctrl[CTRL_BUF_A])
        begin
          s_d.ch[c].gra = s_q.ch[c].bufa;
        end
        if (wr && ofs == OFS_BUFA)
        begin
          s_d.ch[c].bufa = pwdata[CW-1:0];
        end
      end
      if (evt.cap_b[c] && s_q.ch[c].ctrl[CTRL_CAP_B])
      begin
        s_d.ch[c].grb = cnt;
      end
      else if (wr && ofs == OFS_GRB)
      begin
        s_d.ch[c].grb = pwdata[CW-1:0];
      end

      if (wr && ofs == OFS_CTRL)
      begin
        s_d.ch[c].ctrl = pwdata[CTRL_W-1:0];
      end
      if (wr && ofs == OFS_IEN)
      begin
        s_d.ch[c].ien = pwdata[2:0];
      end

      // status flags: a read arms each flag seen at 1; writing 0 then clears
      for (int k = 0; k < 3; k++)
      begin
        if (rd && ofs == OFS_STAT && s_q.ch[c].stat[k])
        begin
          s_d.ch[c].armed[k] = 1'b1;
        end
        if (wr && ofs == OFS_STAT && !pwdata[k] && s_q.ch[c].armed[k])
        begin
          s_d.ch[c].stat[k] = 1'b0;
          s_d.ch[c].armed[k] = 1'b0;
        end
      end
      // an event in the clearing cycle still sets its flag
      if (match_a || (evt.cap_a[c] && s_q.ch[c].ctrl[CTRL_CAP_A]))
      begin
        s_d.ch[c].stat[ST_A] = 1'b1;
        if (c < NDMA && s_q.dma_en[c])
        begin
          s_d.dma[c] = 1'b1;
        end
      end
      if (match_b || (evt.cap_b[c] && s_q.ch[c].ctrl[CTRL_CAP_B]))
      begin
        s_d.ch[c].stat[ST_B] = 1'b1;
      end
      if (wrap)
      begin
        s_d.ch[c].stat[ST_WRAP] = 1'b1;
      end
    end

    // global writes
    if (acc && pwrite)
    begin
      case (paddr)
        ADDR_SYNC: s_d.sync = pwdata[NCH-1:0];
        ADDR_DMAEN: s_d.dma_en = pwdata[NDMA-1:0];
        ADDR_PRIO_FIRST: s_d.prio_reg_first = pwdata[15:0];
        ADDR_PRIO_SECOND: s_d.prio_reg_second = pwdata[15:0];
        ADDR_COMBO:
        begin
          // no guard: software keeps channels 3 and 4 stopped
          s_d.combo_mode_hi = pwdata[1];
          s_d.combo_mode_lo = pwdata[0];
        end
        default: ;
      endcase
    end

    // read data sampled from pre-edge state: a capture in this cycle is unseen
    s_d.rdata = '0;
    if (psel && !penable && !pwrite)
    begin
      if (paddr[11:8] == CH_BASE[11:8] && paddr[7:5] < 3'(NCH))
      begin
        for (int c = 0; c < NCH; c++)
        begin
          if (paddr[7:5] == 3'(c))
          begin
            case (paddr[4:0])
              OFS_COUNT: s_d.rdata = {16'h0000, s_q.ch[c].count};
              OFS_GRA: s_d.rdata = {16'h0000, s_q.ch[c].gra};
              OFS_GRB: s_d.rdata = {16'h0000, s_q.ch[c].grb};
              OFS_BUFA: s_d.rdata = {16'h0000, s_q.ch[c].bufa};
              OFS_CTRL: s_d.rdata = {25'h0000000, s_q.ch[c].ctrl};
              OFS_STAT: s_d.rdata = {29'h00000000, s_q.ch[c].stat};
              OFS_IEN: s_d.rdata = {29'h00000000, s_q.ch[c].ien};
              default: s_d.rdata = '0;
            endcase
          end
        end
      end
      else
      begin
        case (paddr)
          ADDR_SYNC: s_d.rdata = {27'h0000000, s_q.sync};
          ADDR_DMAEN: s_d.rdata = {28'h0000000, s_q.dma_en};
          ADDR_PRIO_FIRST: s_d.rdata = {16'h0000, s_q.prio_reg_first};
          ADDR_PRIO_SECOND: s_d.rdata = {16'h0000, s_q.prio_reg_second};
          ADDR_COMBO: s_d.rdata = {30'h00000000, s_q.combo_mode_hi, s_q.combo_mode_lo};
          ADDR_PEND: s_d.rdata = {17'h00000, pend};
          default: s_d.rdata = '0;
        endcase
      end
    end
    else if (acc)
    begin
      s_d.rdata = s_q.rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        s_q.ch[c].gra <= GR_RST;
        s_q.ch[c].grb <= GR_RST;
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule // timer_irq_unit

// ==== tb/timer_irq_asserts.sv ====
module timer_irq_asserts
  import tmr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire evt_t evt,
  input wire logic [NSRC-1:0] irq_lines,
  input wire logic [NSRC-1:0] irq_grant,
  input wire logic [NDMA-1:0] dma_ctrl_req
);
  logic [NDMA-1:0] prev_a_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prev_a_q <= '0;
    else
      prev_a_q <= evt.incr[NDMA-1:0] | evt.cap_a[NDMA-1:0];
  //////////////////////////////////////////////////
  sequence quiet;
    !(psel && penable && pwrite) && (evt == '0);
  endsequence
  sequence steady_pend;
    (irq_lines != '0) ##1 (irq_lines == $past(irq_lines));
  endsequence
  dma_cause_a: assert property ((dma_ctrl_req & ~prev_a_q) == '0)
    else $error("dma request without a channel A event");
  dma_quiet_a: assert property ((dma_ctrl_req != '0) |->
    (dma_ctrl_req & {irq_lines[9], irq_lines[6], irq_lines[3], irq_lines[0]}) == '0)
    else $error("cpu request raised beside dma request");
  grant_onehot_a: assert property ($onehot0(irq_grant))
    else $error("more than one grant");
  grant_pend_a: assert property ((irq_grant & ~irq_lines) == '0)
    else $error("grant without pending line");
  grant_src_a: assert property ((irq_grant != '0) |->
    (irq_grant & $past(irq_lines)) == irq_grant)
    else $error("grant not from last pending set");
  grant_given_a: assert property (steady_pend |-> irq_grant != '0)
    else $error("pending lines but no grant");
  line_cause_a: assert property (quiet ##1 1'b1 |-> irq_lines == $past(irq_lines))
    else $error("request lines moved with no cause");
  line_fall_a: assert property (!(psel && penable && pwrite) |=>
    ($past(irq_lines) & ~irq_lines) == '0)
    else $error("request line dropped without a write");
endmodule // timer_irq_asserts

bind timer_irq_unit timer_irq_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .evt(evt), .irq_lines(irq_lines),
  .irq_grant(irq_grant), .dma_ctrl_req(dma_ctrl_req));

// ==== tb/cpu_host.sv ====
// apb master plus a dma side that only counts its requests
module cpu_host
  import tmr_pkg::*;
(
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [NDMA-1:0] dma_ctrl_req,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = '0,
  output logic [31:0] pwdata = '0,
  output logic [3:0] pstrb = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  int dma_hits = 0;
  int timeouts = 0;
  always @(posedge pclk)
    dma_hits <= dma_hits + $countones(dma_ctrl_req);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      timeouts++;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show garbage, not a held value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // cpu_host

// ==== tb/timer_irq_and_access_contention_bench.sv ====
module timer_irq_and_access_contention_bench
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [NSRC-1:0] irq_lines, irq_grant, exp_l;
  logic [NDMA-1:0] dma_ctrl_req;
  evt_t evt = '0;
  logic [31:0] seed = 32'h132F;
  int n_mismatch = 0;
  int checks = 0;
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  cpu_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .dma_ctrl_req(dma_ctrl_req),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  timer_irq_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .irq_lines(irq_lines),
    .irq_grant(irq_grant), .dma_ctrl_req(dma_ctrl_req));
  //////////////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [11:0] ca(int c, logic [4:0] o);
    return CH_BASE + 12'(c) * CH_STRIDE + {7'h0, o};
  endfunction
  function automatic evt_t ev(logic [4:0] i, logic [4:0] a, logic [4:0] b);
    return '{incr: i, cap_a: a, cap_b: b};
  endfunction
  // promoted channels first, then the rest, lowest index wins
  function automatic logic [14:0] pick(logic [14:0] l, logic [4:0] pr);
    for (int k = 0; k < 30; k++)
      if (l[k % 15] && (pr[(k % 15) / 3] == (k < 15)))
        return 15'h1 << (k % 15);
    return '0;
  endfunction
  task automatic complete_run();
    n_mismatch += host.timeouts;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic pulse(input evt_t e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= '0;
  endtask
  // event lands on the access edge of the transfer
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, input evt_t e);
    fork
      host.xfer(w, a, d, s, rd);
      begin
        @(posedge pclk);
        pulse(e);
      end
    join
    if (host.timeouts != 0)
      complete_run();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hF, '0);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0, 4'hF, '0);
    chk(rd, x);
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    rst();
    rdc(ca(0, OFS_COUNT), 32'h0);
    rdc(ca(4, OFS_GRB), 32'hFFFF);
    rdc(12'h1F0, 32'h0);
    $display("test reset values done");
    for (int c = 0; c < NCH; c++)
    begin
      wr(ca(c, OFS_CTRL), 32'h19);
      wr(ca(c, OFS_IEN), 32'h7);
      wr(ca(c, OFS_COUNT), 32'hFFFF);
    end
    seed = xs(seed);
    pulse(ev('1, seed[4:0], seed[9:5]));
    for (int c = 0; c < NCH; c++)
      exp_l[c*3 +: 3] = {1'b1, seed[5+c], seed[c]};
    settle();
    chk(32'(irq_lines), 32'(exp_l));
    chk(32'(irq_grant), 32'(pick(exp_l, 5'h0)));
    wr(ADDR_PRIO_FIRST, {27'h0, seed[14:10]});
    settle();
    chk(32'(irq_grant), 32'(pick(exp_l, seed[14:10])));
    wr(ca(4, OFS_IEN), 32'h0);
    wr(ca(1, OFS_STAT), 32'h0);
    wr(ca(1, OFS_STAT), 32'h7);
    settle();
    chk(32'(irq_lines), 32'(exp_l & 15'h0FFF));
    rdc(ca(1, OFS_STAT), {29'h0, exp_l[5:3]});
    wr(ca(1, OFS_STAT), 32'h0);
    settle();
    chk(32'(irq_lines), 32'(exp_l & 15'h0FC7));
    $display("test flags and priority done");
    rst();
    wr(ca(0, OFS_CTRL), 32'h1);
    wr(ca(0, OFS_COUNT), 32'h12FF);
    acc(1'b1, ca(0, OFS_COUNT), 32'h34, 4'h1, ev(5'h1, 5'h0, 5'h0));
    rdc(ca(0, OFS_COUNT), 32'h1234);
    fork
      host.xfer(1'b1, ca(0, OFS_COUNT), 32'h5600, 4'h2, rd);
      pulse(ev(5'h1, 5'h0, 5'h0));
    join
    rdc(ca(0, OFS_COUNT), 32'h5634);
    acc(1'b1, ca(0, OFS_COUNT), 32'h5678, 4'hF, ev(5'h1, 5'h0, 5'h0));
    rdc(ca(0, OFS_COUNT), 32'h5678);
    wr(ca(0, OFS_COUNT), 32'hFFFF);
    acc(1'b1, ca(0, OFS_COUNT), 32'h55, 4'hF, ev(5'h1, 5'h0, 5'h0));
    rdc(ca(0, OFS_COUNT), 32'h55);
    rdc(ca(0, OFS_STAT), 32'h7);
    wr(ca(0, OFS_STAT), 32'h0);
    wr(ca(0, OFS_GRA), 32'h55);
    acc(1'b1, ca(0, OFS_GRA), 32'h55, 4'hF, ev(5'h1, 5'h0, 5'h0));
    rdc(ca(0, OFS_STAT), 32'h0);
    wr(ca(0, OFS_CTRL), 32'h3);
    wr(ca(0, OFS_GRA), 32'h2);
    wr(ca(0, OFS_COUNT), 32'h0);
    repeat (3) pulse(ev(5'h1, 5'h0, 5'h0));
    rdc(ca(0, OFS_COUNT), 32'h0);
    wr(ca(0, OFS_COUNT), 32'h2);
    acc(1'b1, ca(0, OFS_COUNT), 32'h77, 4'hF, ev(5'h1, 5'h0, 5'h0));
    rdc(ca(0, OFS_COUNT), 32'h0);
    wr(ca(1, OFS_CTRL), 32'hB);
    wr(ca(1, OFS_COUNT), 32'h10);
    acc(1'b1, ca(1, OFS_GRA), 32'h99, 4'hF, ev(5'h0, 5'h2, 5'h0));
    rdc(ca(1, OFS_GRA), 32'h10);
    wr(ca(1, OFS_COUNT), 32'h20);
    pulse(ev(5'h2, 5'h2, 5'h0));
    rdc(ca(1, OFS_COUNT), 32'h0);
    rdc(ca(1, OFS_GRA), 32'h20);
    wr(ca(1, OFS_COUNT), 32'h30);
    acc(1'b0, ca(1, OFS_GRA), 32'h0, 4'hF, ev(5'h0, 5'h2, 5'h0));
    chk(rd, 32'h20);
    wr(ca(1, OFS_CTRL), 32'h29);
    acc(1'b1, ca(1, OFS_BUFA), 32'h99, 4'hF, ev(5'h0, 5'h2, 5'h0));
    rdc(ca(1, OFS_BUFA), 32'h30);
    wr(ca(3, OFS_COUNT), 32'h1234);
    wr(ADDR_SYNC, 32'hC);
    acc(1'b1, ca(2, OFS_COUNT), 32'hAB00, 4'h2, '0);
    rdc(ca(3, OFS_COUNT), 32'hAB00);
    // channels 3 and 4 are stopped here
    wr(ADDR_COMBO, 32'h2);
    wr(ADDR_COMBO, 32'h0);
    wr(ADDR_COMBO, 32'h1);
    rdc(ADDR_COMBO, 32'h1);
    $display("test contention done");
    for (int c = 2; c < NCH; c += 2)
    begin
      wr(ca(c, OFS_CTRL), 32'h9);
      wr(ca(c, OFS_IEN), 32'h1);
    end
    wr(ADDR_DMAEN, 32'hF);
    pulse(ev(5'h0, 5'h14, 5'h0));
    settle();
    chk(32'(host.dma_hits), 32'h1);
    chk(32'(irq_lines[12:6]), 32'h40);
    $display("test dma done");
    complete_run();
  end
endmodule // timer_irq_and_access_contention_bench
